// *** bench/flash_host_model.sv ***
// Host controller model driving framed serial commands
`timescale 1ns/1ps
`default_nettype none
module flash_host_model (
    output logic       o_sck,
    output logic       o_cs_n,
    output logic [3:0] o_io
);
    // Idle: clock still, select high
    initial begin
        o_sck  = 1'b0;
        o_cs_n = 1'b1;
        o_io   = 4'hA;
    end

    // One frame of n bits, msb first, d left aligned
    task automatic frame(input logic [23:0] d, input int n,
                         input logic q);
        int k;
        o_cs_n = 1'b0;
        for (k = 0; k < n; k += (q ? 4 : 1)) begin
            #8 o_io = q ? d[23-k -: 4] : {~o_io[3:1], d[23-k]};
            #8 o_sck = 1'b1;
            #16 o_sck = 1'b0;
        end
        #16 o_cs_n = 1'b1;
        o_io = ~o_io;
    endtask : frame
endmodule : flash_host_model
`default_nettype wire

// *** bench/flash_register_write_protect_tb.sv ***
// Self-checking bench for the register write path
`timescale 1ns/1ps
`default_nettype none
module flash_register_write_protect_tb
    import flash_wp_pkg::*;
;
    logic       clk, rst, wp_n, quad, efail, pfail, sck, cs_n;
    logic [3:0] io;
    logic [7:0] sv, snv, cv, cnv;
    logic       hw, write_enable_latch, busy, seen;
    int         err_count, n_tests;

    flash_host_model host (.o_sck(sck), .o_cs_n(cs_n), .o_io(io));
    flash_register_write_protect #(.ERASE_CNT(40), .PROG_CNT(40)) uut (
        .i_ref_clk(clk), .i_rst(rst), .i_sck(sck), .i_cs_n(cs_n),
        .i_io(io), .i_wp_n(wp_n), .i_four_line_instruction_mode(quad),
        .i_erase_fail(efail), .i_prog_fail(pfail),
        .o_status_one_volatile(sv), .o_status_one_nonvolatile(snv),
        .o_config_one_volatile(cv), .o_config_one_nonvolatile(cnv),
        .o_hw_protected(hw), .o_write_enable_latch(write_enable_latch),
        .o_in_progress_bit(busy));

    // 100 MHz core clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input string nm, input logic [7:0] s, e);
        n_tests++;
        if (s !== e) begin
            err_count++;
            $display("BAD %s exp %h seen %h", nm, e, s);
        end
    endtask : chk

    task automatic wrap_up;
        if (err_count == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : wrap_up

    // Sends a frame, then waits for any update to finish
    task automatic go(input logic [23:0] d, input int n);
        int k;
        host.frame(d, n, quad);
        seen = 1'b0;
        for (k = 0; k < 120; k++) begin
            @(negedge clk);
            seen |= busy;
            if (seen && !busy) break;
        end
        if (busy !== 1'b0) begin
            err_count++;
            $display("BAD busy timeout");
            wrap_up();
        end
        repeat (4) @(posedge clk);
        @(negedge clk);
    endtask : go

    task automatic en;
        go({LATCH_ENABLE_CMD, 16'h0000}, 8);
    endtask : en

    task automatic wr(input logic [15:0] v);
        go({WRITE_REGS_CMD, v}, 24);
    endtask : wr

    task automatic pin(input logic v);
        @(posedge clk) wp_n <= v;
        repeat (8) @(posedge clk);
    endtask : pin

    // Mode change followed by two idle link edges
    task automatic mode(input logic m);
        @(posedge clk) quad <= m;
        host.frame(24'h000000, 2, 1'b0);
        repeat (6) @(posedge clk);
    endtask : mode

    task automatic t_gate;
        wr(16'h1C00);
        chk("no_latch", snv, 8'h00);
        go({LATCH_ENABLE_CMD, 16'h0000}, 9);
        chk("en_nine", sv, 8'h00);
        en();
        chk("en", sv, 8'h02);
        chk("wel", {7'h00, write_enable_latch}, 8'h01);
        go({LATCH_DISABLE_CMD, 16'h0000}, 9);
        chk("dis_nine", sv, 8'h02);
        go({LATCH_DISABLE_CMD, 16'h0000}, 8);
        chk("dis", sv, 8'h00);
        wr(16'h1C00);
        chk("dis_wr", snv, 8'h00);
    endtask : t_gate

    task automatic t_route;
        en();
        wr(16'h1C00);
        chk("busy", {7'h00, seen}, 8'h01);
        chk("sv", sv, 8'h1C);
        chk("snv", snv, 8'h1C);
        en();
        wr(16'h0008);
        chk("cnv", cnv, 8'h08);
        en();
        go({WRITE_REGS_CMD, 16'h1400}, 16);
        chk("sv16", sv, 8'h14);
        chk("snv16", snv, 8'h00);
        chk("cv16", cv, 8'h08);
        en();
        go({WRITE_REGS_CMD, 16'hFFFF}, 20);
        chk("abort", sv, 8'h16);
        mode(1'b1);
        en();
        wr(16'h0008);
        chk("quad", sv, 8'h00);
        mode(1'b0);
    endtask : t_route

    task automatic t_protect;
        pin(1'b0);
        en();
        wr(16'h8008);
        chk("status_write_disable", sv, 8'h80);
        chk("hw_on", {7'h00, hw}, 8'h01);
        en();
        wr(16'h1C08);
        chk("reject", sv & 8'hFC, 8'h80);
        pin(1'b1);
        en();
        wr(16'h8408);
        chk("wp_hi", sv, 8'h84);
        pin(1'b0);
        chk("hw_late", {7'h00, hw}, 8'h01);
        pin(1'b1);
        en();
        wr(16'h800A);
        pin(1'b0);
        chk("qe", {7'h00, hw}, 8'h00);
        pin(1'b1);
    endtask : t_protect

    task automatic t_fail;
        @(posedge clk) efail <= 1'b1;
        en();
        wr(16'h1C0A);
        chk("efail", sv, 8'hA0);
        @(posedge clk) efail <= 1'b0;
        pfail <= 1'b1;
        en();
        wr(16'h1C0A);
        chk("pfail", sv, 8'hC0);
        @(posedge clk) pfail <= 1'b0;
    endtask : t_fail

    // Latch disable sent while an update runs
    task automatic t_busy;
        en();
        host.frame({WRITE_REGS_CMD, 16'h800A}, 24, quad);
        repeat (6) @(negedge clk);
        host.frame({LATCH_DISABLE_CMD, 16'h0000}, 8, quad);
        repeat (8) @(negedge clk);
        chk("busy_mid", {7'h00, busy}, 8'h01);
        chk("wel_mid", {7'h00, write_enable_latch}, 8'h01);
        go({LATCH_ENABLE_CMD, 16'h0000}, 9);
        chk("busy_end", sv, 8'h80);
    endtask : t_busy

    // Main sequence
    initial begin
        rst = 1'b1;
        wp_n = 1'b1;
        quad = 1'b0;
        efail = 1'b0;
        pfail = 1'b0;
        err_count = 0;
        n_tests = 0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        chk("rst", sv | snv | cv | cnv, 8'h00);
        t_gate();
        t_route();
        t_protect();
        t_fail();
        t_busy();
        wrap_up();
    end
endmodule : flash_register_write_protect_tb
`default_nettype wire

// *** bench/flash_wp_asserts.sv ***
// Concurrent checks on the register write path ports
`timescale 1ns/1ps
`default_nettype none
module flash_wp_asserts
    import flash_wp_pkg::*;
#(
    parameter int ERASE_CNT = 4,
    parameter int PROG_CNT  = 4
) (
    input wire logic       i_ref_clk,
    input wire logic       i_rst,
    input wire logic       i_sck,
    input wire logic       i_cs_n,
    input wire logic [3:0] i_io,
    input wire logic       i_wp_n,
    input wire logic       i_four_line_instruction_mode,
    input wire logic       i_erase_fail,
    input wire logic       i_prog_fail,
    input wire logic [7:0] o_status_one_volatile,
    input wire logic [7:0] o_status_one_nonvolatile,
    input wire logic [7:0] o_config_one_volatile,
    input wire logic [7:0] o_config_one_nonvolatile,
    input wire logic       o_hw_protected,
    input wire logic       o_write_enable_latch,
    input wire logic       o_in_progress_bit
);
    int busy_len;

    // Counts cycles of one busy stretch
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            busy_len <= 0;
        end else if (!o_in_progress_bit) begin
            busy_len <= 0;
        end else begin
            busy_len <= busy_len + 1;
        end
    end

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    sequence s_done; $fell(o_in_progress_bit); endsequence
    sequence s_wp_idle; i_wp_n [*6]; endsequence
    sequence s_clean; o_status_one_volatile[6:5] == 2'b00; endsequence

    busy_length_a: assert property (s_done ##0 s_clean |->
        busy_len >= ERASE_CNT + PROG_CNT
        && busy_len <= ERASE_CNT + PROG_CNT + 2) else $error("busy length");
    latch_clear_a: assert property (s_done |->
        !o_write_enable_latch) else $error("latch kept after update");
    start_latch_a: assert property ($rose(o_in_progress_bit) |->
        o_write_enable_latch) else $error("update without latch");
    busy_latch_a: assert property (o_in_progress_bit
        && $past(o_in_progress_bit) |-> o_write_enable_latch)
        else $error("latch lost while busy");
    cfg_change_a: assert property ($changed(o_config_one_volatile)
        |-> s_done) else $error("config changed outside update");
    wp_release_a: assert property (s_wp_idle |->
        !o_hw_protected) else $error("protection with pin high");
    quad_free_a: assert property (o_config_one_volatile[1]
        && $past(o_config_one_volatile[1]) |-> !o_hw_protected)
        else $error("protection with quad enable");
    bp_frozen_a: assert property (o_hw_protected
        && !o_in_progress_bit |=> $stable(o_status_one_nonvolatile[4:2])
        && $stable(o_status_one_volatile[4:2]))
        else $error("block bits changed under protection");
endmodule : flash_wp_asserts

bind flash_register_write_protect flash_wp_asserts #(
    .ERASE_CNT(ERASE_CNT), .PROG_CNT(PROG_CNT)) u_chk (
    .i_ref_clk, .i_rst, .i_sck, .i_cs_n, .i_io, .i_wp_n,
    .i_four_line_instruction_mode, .i_erase_fail, .i_prog_fail,
    .o_status_one_volatile, .o_status_one_nonvolatile,
    .o_config_one_volatile, .o_config_one_nonvolatile,
    .o_hw_protected, .o_write_enable_latch, .o_in_progress_bit);
`default_nettype wire

// *** verilog/flash_register_write_protect.sv ***
// Register write path with write enable latch and block protection
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Opcode 01h loads status and config bytes
// - Register write needs latch set beforehand
// - Update erases then programs; failures set flags
// - Sixteen bits: status; twenty-four: both; else abort
// - Update starts at chip select rise; busy
// - Latch clears when update completes
// - Four-line mode: two clocks per byte
// - Protect select routes block bits
// - Disable bit zero: pin level ignored
// - Disable bit one, pin high: writes allowed
// - Disable bit one, pin low: silent reject
// - Hardware protection freezes protected region bits
// - Protection follows last of pin, bit
// - Quad enable turns pin protection off
// - Status register resets to 00h
// - Opcode 06h sets the latch
// - Latch enable needs exactly eight bits
// - Opcode 04h clears the latch
// - Latch disable ignored while busy
// - Latch disable needs exactly eight bits
// - Gated commands need latch at decode
// - Busy indication is volatile status bit 0
// - Erase fail bit 5, program fail bit 6
module flash_register_write_protect
    import flash_wp_pkg::*;
#(
    parameter int ERASE_CNT = ERASE_CYCLES,
    parameter int PROG_CNT  = PROG_CYCLES
) (
    input  wire logic       i_ref_clk,
    input  wire logic       i_rst,
    input  wire logic       i_sck,
    input  wire logic       i_cs_n,
    input  wire logic [3:0] i_io,
    input  wire logic       i_wp_n,
    input  wire logic       i_four_line_instruction_mode,
    input  wire logic       i_erase_fail,
    input  wire logic       i_prog_fail,
    output logic [7:0]      o_status_one_volatile,
    output logic [7:0]      o_status_one_nonvolatile,
    output logic [7:0]      o_config_one_volatile,
    output logic [7:0]      o_config_one_nonvolatile,
    output logic            o_hw_protected,
    output logic            o_write_enable_latch,
    output logic            o_in_progress_bit
);

    //--------------------------------------------------------------
    // Link domain: serial shift on the serial clock
    //--------------------------------------------------------------
    // Link-domain state and next-count wires
    logic [1:0]  quad_sync_r;
    logic        first_r;
    logic [23:0] shift_r;
    logic [5:0]  bits_r;
    logic        frame_tog_r;
    logic [5:0]  step;
    logic [5:0]  bits_nxt;

    // Mode setting crosses into the link domain
    always_ff @(posedge i_sck or posedge i_rst) begin
        if (i_rst) begin
            quad_sync_r <= 2'h0;
        end else begin
            quad_sync_r <= {quad_sync_r[0], i_four_line_instruction_mode};
        end
    end

    // Start-of-frame flag, rearmed while chip select is high
    // Reset also arms it so the first frame after power-up counts
    always_ff @(posedge i_sck or posedge i_cs_n or posedge i_rst) begin
        if (i_rst) begin
            first_r <= 1'b1;
        end else if (i_cs_n) begin
            first_r <= 1'b1;
        end else begin
            first_r <= 1'b0;
        end
    end

    // Four bits per edge in four-line mode
    assign step = quad_sync_r[1] ? STEP_QUAD : STEP_SINGLE;

    // Bit count saturates so long frames still abort
    always_comb begin
        if (first_r) begin
            bits_nxt = step;
        end else if (bits_r > BITS_SAT - step) begin
            bits_nxt = BITS_SAT;
        end else begin
            bits_nxt = bits_r + step;
        end
    end

    // Shift data, count bits; held static after the frame
    always_ff @(posedge i_sck or posedge i_rst) begin
        if (i_rst) begin
            shift_r <= 24'h000000;
            bits_r  <= 6'h00;
        end else if (!i_cs_n) begin
            bits_r <= bits_nxt;
            if (quad_sync_r[1]) begin
                shift_r <= {shift_r[19:0], i_io};
            end else begin
                shift_r <= {shift_r[22:0], i_io[0]};
            end
        end
    end

    // Toggle marks a frame that carried at least one edge
    always_ff @(posedge i_sck or posedge i_rst) begin
        if (i_rst) begin
            frame_tog_r <= 1'b0;
        end else if (!i_cs_n && first_r) begin
            frame_tog_r <= ~frame_tog_r;
        end
    end

    //--------------------------------------------------------------
    // Reference domain: synchronisers and frame capture
    //--------------------------------------------------------------
    // Synchroniser stages and frame-end detection
    logic [1:0] cs_sync_r;
    logic       cs_prev_r;
    logic [1:0] tog_sync_r;
    logic       tog_seen_r;
    logic [1:0] wp_sync_r;
    logic       cs_rise;
    logic       new_frame;
    frame_s     frame;

    // Chip select, frame toggle and protect pin synchronisers
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            cs_sync_r  <= 2'h3;
            cs_prev_r  <= 1'b1;
            tog_sync_r <= 2'h0;
            tog_seen_r <= 1'b0;
            wp_sync_r  <= 2'h3;
        end else begin
            cs_sync_r  <= {cs_sync_r[0], i_cs_n};
            cs_prev_r  <= cs_sync_r[1];
            tog_sync_r <= {tog_sync_r[0], frame_tog_r};
            wp_sync_r  <= {wp_sync_r[0], i_wp_n};
            if (cs_rise) begin
                tog_seen_r <= tog_sync_r[1];
            end
        end
    end

    // One frame accepted per chip select rise with a new toggle
    assign cs_rise   = cs_sync_r[1] & ~cs_prev_r;
    assign new_frame = cs_rise & (tog_sync_r[1] != tog_seen_r);

    // Link data is static once chip select is high
    always_comb begin
        frame.nbits       = bits_r;
        frame.opcode      = 8'h00;
        frame.status_byte = 8'h00;
        frame.config_byte = 8'h00;
        if (bits_r == BITS_INSTR) begin
            frame.opcode = shift_r[7:0];
        end else if (bits_r == BITS_ONE) begin
            frame.opcode      = shift_r[15:8];
            frame.status_byte = shift_r[7:0];
        end else if (bits_r == BITS_TWO) begin
            frame.opcode      = shift_r[23:16];
            frame.status_byte = shift_r[15:8];
            frame.config_byte = shift_r[7:0];
        end
    end

    //--------------------------------------------------------------
    // Command decode and protection
    //--------------------------------------------------------------
    // Register images and command qualifiers
    logic [7:0] sr_nv_r;
    logic [7:0] sr_v_r;
    logic [7:0] cr_nv_r;
    logic [7:0] cr_v_r;
    logic       busy;
    logic       write_enable_latch;
    logic       hw_prot;
    logic       is_wrr;
    logic       wrr_ok;
    logic       latch_enable_cmd_ok;
    logic       latch_disable_cmd_ok;

    // Busy and latch are plain views of volatile status
    assign busy = sr_v_r[IN_PROGRESS_BIT];
    assign write_enable_latch  = sr_v_r[WEL_BIT];

    // Pin protection is level based, so last event wins
    assign hw_prot = sr_nv_r[STATUS_WD_BIT] & ~wp_sync_r[1]
                   & ~cr_v_r[QUAD_ENABLE_BIT];

    // Only a legal length counts; a cut byte never decodes
    assign is_wrr = new_frame && frame.opcode == WRITE_REGS_CMD
                  && (frame.nbits == BITS_ONE
                      || frame.nbits == BITS_TWO);

    // Register write gated by latch, busy and protection
    assign wrr_ok = is_wrr && write_enable_latch && !busy
                  && !hw_prot;

    // Latch commands need exactly one byte and an idle sequencer
    assign latch_enable_cmd_ok = new_frame && frame.nbits == BITS_INSTR
                   && frame.opcode == LATCH_ENABLE_CMD
                   && !busy;

    assign latch_disable_cmd_ok = new_frame && frame.nbits == BITS_INSTR
                   && frame.opcode == LATCH_DISABLE_CMD
                   && !busy;

    //--------------------------------------------------------------
    // Self-timed erase-then-program sequencer
    //--------------------------------------------------------------
    // Sequencer state, phase timer and held write data
    upd_state_e       state_r;
    logic [TMR_W-1:0] tmr_r;
    logic [7:0]       pend_sr_r;
    logic [7:0]       pend_cr_r;
    logic             pend_two_r;
    logic             tmr_done;
    logic             commit;
    logic             fail_erase;
    logic             fail_prog;

    // Phase ends when the timer reaches zero
    assign tmr_done   = tmr_r == '0;
    assign fail_erase = state_r == ST_ERASE && tmr_done && i_erase_fail;
    assign fail_prog  = state_r == ST_PROGRAM && tmr_done && i_prog_fail;
    assign commit     = state_r == ST_PROGRAM && tmr_done && !i_prog_fail;

    // Erase phase then program phase as one operation
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            state_r <= ST_IDLE;
            tmr_r   <= '0;
        end else begin
            unique case (state_r)
                ST_IDLE: begin
                    if (wrr_ok) begin
                        state_r <= ST_ERASE;
                        tmr_r   <= TMR_W'(ERASE_CNT - 1);
                    end
                end
                ST_ERASE: begin
                    if (!tmr_done) begin
                        tmr_r <= tmr_r - 1'b1;
                    end else if (i_erase_fail) begin
                        state_r <= ST_IDLE;
                    end else begin
                        state_r <= ST_PROGRAM;
                        tmr_r   <= TMR_W'(PROG_CNT - 1);
                    end
                end
                ST_PROGRAM: begin
                    if (!tmr_done) begin
                        tmr_r <= tmr_r - 1'b1;
                    end else begin
                        state_r <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Data held for the update
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            pend_sr_r  <= STATUS_RESET;
            pend_cr_r  <= CONFIG_RESET;
            pend_two_r <= 1'b0;
        end else if (wrr_ok) begin
            pend_sr_r  <= frame.status_byte;
            pend_cr_r  <= frame.config_byte;
            pend_two_r <= frame.nbits == BITS_TWO;
        end
    end

    //--------------------------------------------------------------
    // Status and configuration registers
    //--------------------------------------------------------------
    // Nonvolatile status: block bits only when select is 0
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            sr_nv_r <= STATUS_RESET;
        end else if (commit) begin
            sr_nv_r[STATUS_WD_BIT] <= pend_sr_r[STATUS_WD_BIT];
            if (!cr_nv_r[PROTECT_SEL_BIT]) begin
                sr_nv_r[BP_HI:BP_LO] <= pend_sr_r[BP_HI:BP_LO];
            end
        end
    end

    // Volatile status: busy, latch, fail flags, block bits
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            sr_v_r <= STATUS_RESET;
        end else begin
            if (wrr_ok) begin
                sr_v_r[IN_PROGRESS_BIT] <= 1'b1;
                sr_v_r[ERASE_FAIL_BIT]  <= 1'b0;
                sr_v_r[PROG_FAIL_BIT]   <= 1'b0;
            end else if (commit || fail_erase || fail_prog) begin
                sr_v_r[IN_PROGRESS_BIT] <= 1'b0;
                sr_v_r[WEL_BIT]         <= 1'b0;
            end else if (latch_enable_cmd_ok) begin
                sr_v_r[WEL_BIT] <= 1'b1;
            end else if (latch_disable_cmd_ok) begin
                sr_v_r[WEL_BIT] <= 1'b0;
            end
            if (fail_erase) begin
                sr_v_r[ERASE_FAIL_BIT] <= 1'b1;
            end
            if (fail_prog) begin
                sr_v_r[PROG_FAIL_BIT] <= 1'b1;
            end
            if (commit) begin
                sr_v_r[STATUS_WD_BIT] <= pend_sr_r[STATUS_WD_BIT];
                sr_v_r[BP_HI:BP_LO]   <= pend_sr_r[BP_HI:BP_LO];
            end
        end
    end

    // Configuration registers change only on two-byte writes
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            cr_nv_r <= CONFIG_RESET;
            cr_v_r  <= CONFIG_RESET;
        end else if (commit && pend_two_r) begin
            cr_nv_r <= pend_cr_r;
            cr_v_r  <= pend_cr_r;
        end
    end

    //--------------------------------------------------------------
    // Registered outputs
    //--------------------------------------------------------------
    // Protection level drives array gating
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_hw_protected <= 1'b0;
        end else begin
            o_hw_protected <= hw_prot;
        end
    end

    // Register images and latch state for other commands
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_status_one_volatile    <= STATUS_RESET;
            o_status_one_nonvolatile <= STATUS_RESET;
            o_config_one_volatile    <= CONFIG_RESET;
            o_config_one_nonvolatile <= CONFIG_RESET;
            o_write_enable_latch     <= 1'b0;
            o_in_progress_bit        <= 1'b0;
        end else begin
            o_status_one_volatile    <= sr_v_r;
            o_status_one_nonvolatile <= sr_nv_r;
            o_config_one_volatile    <= cr_v_r;
            o_config_one_nonvolatile <= cr_nv_r;
            o_write_enable_latch     <= write_enable_latch;
            o_in_progress_bit        <= busy;
        end
    end

endmodule : flash_register_write_protect
`default_nettype wire

// *** verilog/flash_wp_pkg.sv ***
// Constants, types and encodings for the register write path
`default_nettype none
package flash_wp_pkg;
    // Instruction codes
    localparam logic [7:0] WRITE_REGS_CMD    = 8'h01;
    localparam logic [7:0] LATCH_ENABLE_CMD  = 8'h06;
    localparam logic [7:0] LATCH_DISABLE_CMD = 8'h04;
    // Frame lengths in bits
    localparam logic [5:0] BITS_INSTR  = 6'h08;
    localparam logic [5:0] BITS_ONE    = 6'h10;
    localparam logic [5:0] BITS_TWO    = 6'h18;
    localparam logic [5:0] BITS_SAT    = 6'h3F;
    localparam logic [5:0] STEP_SINGLE = 6'h01;
    localparam logic [5:0] STEP_QUAD   = 6'h04;
    // Volatile status bit positions
    localparam int IN_PROGRESS_BIT  = 0;
    localparam int WEL_BIT          = 1;
    localparam int BP_LO            = 2;
    localparam int BP_HI            = 4;
    localparam int ERASE_FAIL_BIT   = 5;
    localparam int PROG_FAIL_BIT    = 6;
    localparam int STATUS_WD_BIT    = 7;
    // Configuration bit positions
    localparam int QUAD_ENABLE_BIT  = 1;
    localparam int PROTECT_SEL_BIT  = 3;
    // Reset values
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] CONFIG_RESET = 8'h00;
    // Self-timed update durations
    localparam int CLK_MHZ        = 100;
    localparam int ERASE_TIME_NS  = 1000;
    localparam int PROG_TIME_NS   = 1000;
    localparam int ERASE_CYCLES   = (ERASE_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam int PROG_CYCLES    = (PROG_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam int TMR_W          = 16;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ERASE,
        ST_PROGRAM
    } upd_state_e;

    // One received frame as seen when chip select rises
    typedef struct packed {
        logic [7:0] opcode;
        logic [7:0] status_byte;
        logic [7:0] config_byte;
        logic [5:0] nbits;
    } frame_s;
endpackage : flash_wp_pkg
`default_nettype wire
